// *** hdl/res_delay_timer.sv ***
// Millisecond edge delay timer, restarted per edge
`timescale 1ns/100ps
`default_nettype none
module res_delay_timer import res_pkg::*; #(
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Control
  input  wire logic       restart,
  input  wire logic [2:0] delayCode,
  // Status
  output logic            expired
);

  logic [PRE_W-1:0]    pre_reg;
  logic [DLY_MS_W-1:0] ms_reg;
  logic [DLY_MS_W-1:0] target_reg;
  logic                running_reg;
  logic                expired_reg;
  int                  elapsed;

  // ---------------------------------------------------------------
  // Counter, prescaler restarts with every edge
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pre_reg     <= '0;
      ms_reg      <= '0;
      target_reg  <= '0;
      running_reg <= 1'b0;
      expired_reg <= 1'b0;
    end else if (restart) begin
      pre_reg     <= '0;
      ms_reg      <= '0;
      target_reg  <= res_delay_ms(delayCode);
      running_reg <= 1'b1;
      expired_reg <= 1'b0;
    end else if (running_reg) begin
      if (ms_reg == target_reg) begin
        running_reg <= 1'b0;
        expired_reg <= 1'b1;
      end else if (pre_reg == PRE_W'(MS_TICK_CYCLES - 1)) begin
        pre_reg <= '0;
        ms_reg  <= ms_reg + 7'h01;
      end else begin
        pre_reg <= pre_reg + 24'h000001;
      end
    end
  end

  assign expired = expired_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn || restart) begin
      elapsed <= 0;
    end else if (running_reg) begin
      elapsed <= elapsed + 1;
    end
  end

  a_delay_exact: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(expired_reg) |-> elapsed == int'(target_reg) * MS_TICK_CYCLES + 1)
    else $error("Edge delay differs from programmed value");

endmodule
`default_nettype wire

// *** hdl/res_pkg.sv ***
// Constants, register map and reset banks of the rail enable sequencer
package res_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_UNIT_NS    = 1000000;
  localparam int MS_CYCLES     = MS_UNIT_NS / CLK_PERIOD_NS;
  localparam int PRE_W         = 24;
  localparam int DLY_MS_W      = 7;

  // ---------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] RC1_MASK_IDX = 8'h07;
  localparam logic [7:0] RC1_CFG_IDX  = 8'h08;
  localparam logic [7:0] RC1_DLY_IDX  = 8'h09;
  localparam logic [7:0] RC2_MASK_IDX = 8'h0a;
  localparam logic [7:0] STATUS_IDX   = 8'h30;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CFG_SWB_BIT    = 0;
  localparam int CFG_SHARED_BIT = 1;
  localparam int CFG_SEL_LSB    = 2;
  localparam int CFG_STEP_BIT   = 5;
  localparam int DLY_ON_LSB     = 0;
  localparam int DLY_OFF_LSB    = 3;

  // ---------------------------------------------------------------
  // Enable source codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_IN1    = 3'h0;
  localparam logic [2:0] SEL_IN2    = 3'h1;
  localparam logic [2:0] SEL_IN5    = 3'h2;
  localparam logic [2:0] SEL_IN4    = 3'h3;
  localparam logic [2:0] SEL_IN3    = 3'h4;
  localparam logic [2:0] SEL_IN3_4  = 3'h5;
  localparam logic [2:0] SEL_IN6    = 3'h6;
  localparam logic [2:0] SEL_ALWAYS = 3'h7;

  // ---------------------------------------------------------------
  // Synchroniser vector positions
  // ---------------------------------------------------------------
  localparam int SYN_W      = 18;
  localparam int SYN_EN_LSB = 0;
  localparam int SYN_BANK   = 6;
  localparam int SYN_PG_LSB = 7;
  localparam int SYN_PG_C3  = 8;
  localparam int SYN_PG_MSB = 14;
  localparam int SYN_SWB    = 15;
  localparam int SYN_SHARED = 16;
  localparam int SYN_PG_C1  = 17;

  // ---------------------------------------------------------------
  // Reset values of the two stored banks
  // ---------------------------------------------------------------
  localparam logic [7:0] BANK0_RC1_MASK = 8'h00;
  localparam logic [7:0] BANK0_RC1_CFG  = 8'hc0;
  localparam logic [7:0] BANK0_RC1_DLY  = 8'h00;
  localparam logic [7:0] BANK0_RC2_MASK = 8'h00;
  localparam logic [7:0] BANK1_RC1_MASK = 8'hff;
  localparam logic [7:0] BANK1_RC1_CFG  = 8'hdf;
  localparam logic [7:0] BANK1_RC1_DLY  = 8'h09;
  localparam logic [7:0] BANK1_RC2_MASK = 8'hff;

  typedef enum logic [1:0] {ST_OFF, ST_WAIT_ON, ST_ON, ST_WAIT_OFF} res_state_t;

  // Delay code to milliseconds
  function automatic logic [DLY_MS_W-1:0] res_delay_ms(input logic [2:0] code);
    logic [DLY_MS_W-1:0] ms;
    case (code)
      3'h0: ms = 7'h00;
      3'h1: ms = 7'h02;
      3'h2: ms = 7'h04;
      3'h3: ms = 7'h08;
      3'h4: ms = 7'h10;
      3'h5: ms = 7'h18;
      3'h6: ms = 7'h20;
      default: ms = 7'h40;
    endcase
    return ms;
  endfunction

endpackage

// *** hdl/res_rail_sequencer.sv ***
// Rail enable sequencer: masks, source select, edge delays, register slave
//
// Behaviour
// - rail_c1 eight-bit mask over other rails' power_good
// - Mask 0 uses power_good, 1 ignores it
// - Config bits 1,0 mask shared slot, switch_b
// - Bits 4:2 choose which enable input drives
// - Code 111 enables without any pin
// - Bit 5 selects 10 mV or 25 mV step
// - Bits 5:3 delay response to falling enable
// - Bits 2:0 delay response to rising enable
// - Delays stay within ten percent of nominal
// - rail_c2 mask, bit 0 masks rail_c1
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module res_rail_sequencer import res_pkg::*; #(
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Enable input pins
  input  wire logic        enableInput1,
  input  wire logic        enableInput2,
  input  wire logic        enableInput3,
  input  wire logic        enableInput4,
  input  wire logic        enableInput5,
  input  wire logic        enableInput6,
  // Reset bank select strap
  input  wire logic        otpBankSelect,
  // Power good of other rails
  input  wire logic        pgoodRailC1,
  input  wire logic        pgoodRailC2,
  input  wire logic        pgoodRailC3,
  input  wire logic        pgoodRailD4,
  input  wire logic        pgoodRailD5,
  input  wire logic        pgoodRailD6,
  input  wire logic        pgoodSwitchA,
  input  wire logic        pgoodLdoGp2,
  input  wire logic        pgoodLdoGp3,
  input  wire logic        pgoodSwitchB,
  input  wire logic        pgoodSharedSlot,
  // Rail controls
  output logic             railC1Enable,
  output logic             railC1VoltageStep,
  output logic             railC2PgoodOk
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [SYN_W-1:0] rawIn;
  logic [SYN_W-1:0] syncA_reg;
  logic [SYN_W-1:0] syncB_reg;
  logic [7:0]       rc1Mask_reg;
  logic [7:0]       rc1Cfg_reg;
  logic [7:0]       rc1Dly_reg;
  logic [7:0]       rc2Mask_reg;
  logic             loadPending_reg;
  logic             ackPending_reg;
  logic [31:0]      readData_reg;
  logic [7:0]       regIdx;
  logic             busWr;
  logic             busRd;
  logic [31:0]      readValue;
  logic [7:0]       rc1PgVec;
  logic [7:0]       rc2PgVec;
  logic             rc1PgoodOk;
  logic             rc1PgoodOk_reg;
  logic             rc2PgoodOk_reg;
  logic [2:0]       enableSource;
  logic             selEnable;
  res_state_t       state_reg;
  res_state_t       state_next;
  logic             timerRestart;
  logic [2:0]       timerCode;
  logic             timerExpired;
  logic             railC1Enable_reg;
  int               waitCnt;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  assign rawIn = {pgoodRailC1, pgoodSharedSlot, pgoodSwitchB, pgoodLdoGp3,
                  pgoodLdoGp2, pgoodSwitchA, pgoodRailD6, pgoodRailD5,
                  pgoodRailD4, pgoodRailC3, pgoodRailC2, otpBankSelect,
                  enableInput6, enableInput5, enableInput4, enableInput3,
                  enableInput2, enableInput1};

  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        syncA_reg[gi] <= rawIn[gi];
        syncB_reg[gi] <= syncA_reg[gi];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Avalon-MM handshake, one wait state per access
  // ---------------------------------------------------------------
  assign regIdx          = avs_address[9:2];
  assign avs_waitrequest = (avs_read | avs_write) & ~ackPending_reg;
  assign busWr           = avs_write & ackPending_reg & avs_byteenable[0];
  assign busRd           = avs_read & ~ackPending_reg;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ackPending_reg <= 1'b0;
    end else begin
      ackPending_reg <= (avs_read | avs_write) & ~ackPending_reg;
    end
  end

  // ---------------------------------------------------------------
  // Read mux, unmapped words read zero
  // ---------------------------------------------------------------
  always_comb begin
    readValue = 32'h00000000;
    case (regIdx)
      RC1_MASK_IDX: readValue[7:0] = rc1Mask_reg;
      RC1_CFG_IDX:  readValue[7:0] = rc1Cfg_reg;
      RC1_DLY_IDX:  readValue[7:0] = rc1Dly_reg;
      RC2_MASK_IDX: readValue[7:0] = rc2Mask_reg;
      STATUS_IDX:   readValue[7:0] = {3'h0, timerExpired, rc2PgoodOk_reg,
                                      rc1PgoodOk_reg, selEnable, railC1Enable_reg};
      default:      readValue = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      readData_reg <= 32'h00000000;
    end else if (busRd) begin
      readData_reg <= readValue;
    end
  end

  assign avs_readdata = readData_reg;

  // ---------------------------------------------------------------
  // Configuration registers with bank load after reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      loadPending_reg <= 1'b1;
    end else begin
      loadPending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rc1Mask_reg <= BANK0_RC1_MASK;
      rc1Cfg_reg  <= BANK0_RC1_CFG;
      rc1Dly_reg  <= BANK0_RC1_DLY;
      rc2Mask_reg <= BANK0_RC2_MASK;
    end else if (loadPending_reg) begin
      rc1Mask_reg <= syncB_reg[SYN_BANK] ? BANK1_RC1_MASK : BANK0_RC1_MASK;
      rc1Cfg_reg  <= syncB_reg[SYN_BANK] ? BANK1_RC1_CFG  : BANK0_RC1_CFG;
      rc1Dly_reg  <= syncB_reg[SYN_BANK] ? BANK1_RC1_DLY  : BANK0_RC1_DLY;
      rc2Mask_reg <= syncB_reg[SYN_BANK] ? BANK1_RC2_MASK : BANK0_RC2_MASK;
    end else if (busWr) begin
      case (regIdx)
        RC1_MASK_IDX: rc1Mask_reg <= avs_writedata[7:0];
        RC1_CFG_IDX:  rc1Cfg_reg  <= avs_writedata[7:0];
        RC1_DLY_IDX:  rc1Dly_reg  <= avs_writedata[7:0];
        RC2_MASK_IDX: rc2Mask_reg <= avs_writedata[7:0];
        default:      rc1Mask_reg <= rc1Mask_reg;
      endcase
    end
  end

  assign railC1VoltageStep = rc1Cfg_reg[CFG_STEP_BIT];

  // ---------------------------------------------------------------
  // Power good qualification
  // ---------------------------------------------------------------
  assign rc1PgVec = syncB_reg[SYN_PG_MSB:SYN_PG_LSB];
  assign rc2PgVec = {syncB_reg[SYN_PG_MSB:SYN_PG_C3], syncB_reg[SYN_PG_C1]};

  assign rc1PgoodOk = (&(rc1PgVec | rc1Mask_reg))
                    & (syncB_reg[SYN_SHARED] | rc1Cfg_reg[CFG_SHARED_BIT])
                    & (syncB_reg[SYN_SWB] | rc1Cfg_reg[CFG_SWB_BIT]);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rc1PgoodOk_reg <= 1'b0;
      rc2PgoodOk_reg <= 1'b0;
    end else begin
      rc1PgoodOk_reg <= rc1PgoodOk;
      rc2PgoodOk_reg <= &(rc2PgVec | rc2Mask_reg);
    end
  end

  assign railC2PgoodOk = rc2PgoodOk_reg;

  // ---------------------------------------------------------------
  // Enable source select
  // ---------------------------------------------------------------
  assign enableSource = rc1Cfg_reg[CFG_SEL_LSB +: 3];

  always_comb begin
    case (enableSource)
      SEL_IN1:    selEnable = syncB_reg[SYN_EN_LSB];
      SEL_IN2:    selEnable = syncB_reg[SYN_EN_LSB + 1];
      SEL_IN5:    selEnable = syncB_reg[SYN_EN_LSB + 4];
      SEL_IN4:    selEnable = syncB_reg[SYN_EN_LSB + 3];
      SEL_IN3:    selEnable = syncB_reg[SYN_EN_LSB + 2];
      SEL_IN3_4:  selEnable = syncB_reg[SYN_EN_LSB + 2] & syncB_reg[SYN_EN_LSB + 3];
      SEL_IN6:    selEnable = syncB_reg[SYN_EN_LSB + 5];
      SEL_ALWAYS: selEnable = 1'b1;
      default:    selEnable = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Enable sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    timerRestart = 1'b0;
    timerCode    = rc1Dly_reg[DLY_ON_LSB +: 3];
    case (state_reg)
      ST_OFF: begin
        if (selEnable) begin
          state_next   = ST_WAIT_ON;
          timerRestart = 1'b1;
        end
      end
      ST_WAIT_ON: begin
        if (!selEnable) begin
          state_next = ST_OFF;
        end else if (timerExpired && rc1PgoodOk_reg) begin
          state_next = ST_ON;
        end
      end
      ST_ON: begin
        if (!selEnable) begin
          state_next   = ST_WAIT_OFF;
          timerRestart = 1'b1;
          timerCode    = rc1Dly_reg[DLY_OFF_LSB +: 3];
        end
      end
      ST_WAIT_OFF: begin
        if (selEnable) begin
          state_next = ST_ON;
        end else if (timerExpired) begin
          state_next = ST_OFF;
        end
      end
      default: state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg        <= ST_OFF;
      railC1Enable_reg <= 1'b0;
    end else begin
      state_reg        <= state_next;
      railC1Enable_reg <= (state_next == ST_ON) || (state_next == ST_WAIT_OFF);
    end
  end

  assign railC1Enable = railC1Enable_reg;

  res_delay_timer #(
    .MS_TICK_CYCLES (MS_TICK_CYCLES)
  ) u_timer (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .restart   (timerRestart),
    .delayCode (timerCode),
    .expired   (timerExpired)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn || state_reg == ST_OFF || state_reg == ST_ON) begin
      waitCnt <= 0;
    end else begin
      waitCnt <= waitCnt + 1;
    end
  end

  a_enable_needs_power_good: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(railC1Enable) |-> $past(rc1PgoodOk_reg) && $past(selEnable))
    else $error("Enable rose without power good or enable input");

  a_on_delay_min: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(railC1Enable) && $past(state_reg) == ST_WAIT_ON
      |-> waitCnt >= int'(res_delay_ms(rc1Dly_reg[2:0])) * MS_TICK_CYCLES)
    else $error("Enable rose before the rising delay");

  a_off_delay_min: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(railC1Enable) |-> waitCnt >= int'(res_delay_ms(rc1Dly_reg[5:3])) * MS_TICK_CYCLES)
    else $error("Enable fell before the falling delay");

  a_c1_mask_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    !rc1Mask_reg[0] && !syncB_reg[SYN_PG_LSB] |=> !rc1PgoodOk_reg)
    else $error("Unmasked rail_c2 power good ignored");

  a_c1_switch_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    !rc1Cfg_reg[CFG_SWB_BIT] && !syncB_reg[SYN_SWB] |=> !rc1PgoodOk_reg)
    else $error("Unmasked switch_b power good ignored");

  a_c2_all_masked: assert property (@(posedge clk_sys) disable iff (!rstn)
    rc2Mask_reg == 8'hff |=> railC2PgoodOk)
    else $error("Fully masked rail_c2 not qualified");

  a_const_enable: assert property (@(posedge clk_sys) disable iff (!rstn)
    enableSource == SEL_ALWAYS && state_reg == ST_OFF |=> state_reg == ST_WAIT_ON)
    else $error("Constant enable source did not start");

  a_src_and: assert property (@(posedge clk_sys) disable iff (!rstn)
    enableSource == SEL_IN3_4 && !(syncB_reg[2] && syncB_reg[3]) && state_reg == ST_OFF
      |=> state_reg == ST_OFF)
    else $error("Combined source started on a single input");

  a_step_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    busWr && regIdx == RC1_CFG_IDX && !loadPending_reg
      |=> railC1VoltageStep == $past(avs_writedata[5]))
    else $error("Step select did not follow write");

  a_bank_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    loadPending_reg && syncB_reg[SYN_BANK] |=> rc1Cfg_reg == BANK1_RC1_CFG && rc2Mask_reg == BANK1_RC2_MASK)
    else $error("Bank one values not loaded");

endmodule
`default_nettype wire

// *** testbench/test_res_rail_sequencer.sv ***
// Self-checking bench for the rail enable sequencer
`timescale 1ns/100ps
`default_nettype none
module test_res_rail_sequencer import res_pkg::*;;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int TICK = 10;
  localparam int CEIL = 30000;
  logic        clk_sys         = 1'b0;
  logic        rstn            = 1'b0;
  logic [9:0]  avs_address     = 10'h000;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0;
  logic [3:0]  avs_byteenable  = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [5:0]  en              = 6'h00;
  logic [10:0] pg              = 11'h7ff;
  logic        otpBankSelect   = 1'b0;
  logic        railC1Enable;
  logic        railC1VoltageStep;
  logic        railC2PgoodOk;
  int          errTotal        = 0;
  int          nChecks         = 0;
  int          cyc             = 0;
  int          n;
  logic [7:0]  pat;
  logic [7:0]  idxs[4]    = '{8'h07, 8'h08, 8'h09, 8'h0a};
  logic [7:0]  rv0[4]     = '{8'h00, 8'hc0, 8'h00, 8'h00};
  logic [7:0]  rv1[4]     = '{8'hff, 8'hdf, 8'h09, 8'hff};
  logic [5:0]  selMask[8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0c, 6'h20, 6'h00};
  int          dlyMs[8]   = '{0, 2, 4, 8, 16, 24, 32, 64};

  res_rail_sequencer #(.MS_TICK_CYCLES(TICK)) uut (
    .clk_sys(clk_sys), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .enableInput1(en[0]), .enableInput2(en[1]), .enableInput3(en[2]),
    .enableInput4(en[3]), .enableInput5(en[4]), .enableInput6(en[5]),
    .otpBankSelect(otpBankSelect),
    .pgoodRailC1(pg[10]), .pgoodRailC2(pg[0]), .pgoodRailC3(pg[1]),
    .pgoodRailD4(pg[2]), .pgoodRailD5(pg[3]), .pgoodRailD6(pg[4]),
    .pgoodSwitchA(pg[5]), .pgoodLdoGp2(pg[6]), .pgoodLdoGp3(pg[7]),
    .pgoodSwitchB(pg[8]), .pgoodSharedSlot(pg[9]),
    .railC1Enable(railC1Enable), .railC1VoltageStep(railC1VoltageStep),
    .railC2PgoodOk(railC2PgoodOk)
  );

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      errTotal++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task finish_test;
    if (errTotal == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic sigv(input bit c2);
    return c2 ? railC2PgoodOk : railC1Enable;
  endfunction

  task automatic busXfer(input bit wr, input logic [7:0] idx, input logic [7:0] wd,
                         input logic [3:0] be, output logic [31:0] data);
    @(posedge clk_sys);
    avs_address    <= {idx, 2'b00};
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= {24'h0, wd};
    avs_byteenable <= be;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    data = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic busWr(input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be);
    logic [31:0] d;
    busXfer(1'b1, idx, wd, be, d);
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] d;
    busXfer(1'b0, idx, 8'h00, 4'hf, d);
    chk(d, {24'h0, e});
  endtask

  task automatic waitFor(input bit c2, input logic e, input int maxc, output int cnt);
    cnt = 0;
    @(negedge clk_sys);
    while (cnt < maxc && sigv(c2) !== e) begin
      @(negedge clk_sys);
      cnt++;
    end
    chk({31'h0, sigv(c2)}, {31'h0, e});
    @(posedge clk_sys);
  endtask

  task automatic hold(input bit c2, input logic e, input int cycles);
    logic ok;
    ok = 1'b1;
    repeat (cycles) begin
      @(negedge clk_sys);
      if (sigv(c2) !== e) ok = 1'b0;
    end
    chk({31'h0, ok}, 32'h1);
    @(posedge clk_sys);
  endtask

  task automatic chkDly(input int d, input int cnt);
    chk({31'h0, (cnt >= d * TICK * 9 / 10 && cnt <= d * TICK * 11 / 10 + 8)}, 32'h1);
  endtask

  task automatic doReset(input logic b);
    rstn          <= 1'b0;
    otpBankSelect <= b;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    doReset(1'b0);
    foreach (idxs[i]) rdChk(idxs[i], rv0[i]);
    rdChk(8'h30, 8'h0c);
    chk({31'h0, railC1VoltageStep}, 32'h0);
    rdChk(8'h0b, 8'h00);
    busWr(8'h07, 8'h3c, 4'h0);
    rdChk(8'h07, 8'h00);
    foreach (idxs[i]) for (int p = 0; p < 2; p++) begin
      pat = p ? 8'h5a : 8'ha5;
      busWr(idxs[i], pat, 4'h1);
      rdChk(idxs[i], pat);
      if (i == 1) chk({31'h0, railC1VoltageStep}, {31'h0, pat[5]});
    end
    busWr(8'h09, 8'h00, 4'h1);
    for (int i = 0; i < 10; i++) begin
      busWr(8'h07, 8'h00, 4'h1);
      busWr(8'h08, 8'h00, 4'h1);
      en <= 6'h00;
      waitFor(0, 1'b0, 50, n);
      pg <= ~(11'h001 << i);
      en <= 6'h01;
      hold(0, 1'b0, 40);
      if (i < 8) busWr(8'h07, 8'h01 << i, 4'h1);
      else busWr(8'h08, 8'h01 << (i - 8), 4'h1);
      waitFor(0, 1'b1, 40, n);
      pg <= 11'h7ff;
    end
    busWr(8'h07, 8'hff, 4'h1);
    for (int c = 0; c < 8; c++) begin
      en <= 6'h00;
      waitFor(0, 1'b0, 50, n);
      busWr(8'h08, 8'((c << 2) | 3), 4'h1);
      en <= ~selMask[c];
      if (c == 7) waitFor(0, 1'b1, 50, n);
      else hold(0, 1'b0, 20);
      if (c == 5) begin
        en <= ~6'h08;
        hold(0, 1'b0, 20);
      end
      en <= 6'h3f;
      waitFor(0, 1'b1, 50, n);
      en <= ~selMask[c];
      if (c == 7) hold(0, 1'b1, 20);
      else waitFor(0, 1'b0, 50, n);
    end
    for (int i = 0; i < 8; i++) begin
      busWr(8'h0a, 8'h00, 4'h1);
      pg <= ~(11'h001 << ((i == 0) ? 10 : i));
      waitFor(1, 1'b0, 20, n);
      busWr(8'h0a, 8'h01 << i, 4'h1);
      waitFor(1, 1'b1, 20, n);
      pg <= 11'h7ff;
    end
    busWr(8'h08, 8'h03, 4'h1);
    en <= 6'h00;
    waitFor(0, 1'b0, 50, n);
    for (int k = 0; k < 8; k++) begin
      busWr(8'h09, 8'((k << 3) | k), 4'h1);
      en <= 6'h01;
      waitFor(0, 1'b1, 1000, n);
      chkDly(dlyMs[k], n);
      en <= 6'h00;
      waitFor(0, 1'b0, 1000, n);
      chkDly(dlyMs[k], n);
    end
    busWr(8'h09, 8'h03, 4'h1);
    en <= 6'h01;
    hold(0, 1'b0, 20);
    en <= 6'h00;
    hold(0, 1'b0, 120);
    busWr(8'h09, 8'h18, 4'h1);
    en <= 6'h01;
    waitFor(0, 1'b1, 50, n);
    en <= 6'h00;
    hold(0, 1'b1, 20);
    en <= 6'h01;
    hold(0, 1'b1, 120);
    en <= 6'h00;
    doReset(1'b1);
    foreach (idxs[i]) rdChk(idxs[i], rv1[i]);
    waitFor(0, 1'b1, 100, n);
    chkDly(2, n + 8);
    rdChk(8'h30, 8'h1f);
    finish_test();
  end
endmodule
`default_nettype wire
